// [src/card_presence_sensing.sv]
// Card-presence sensing sequencer with its configuration registers.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
module card_presence_sensing
    import sense_pkg::*;
#(
    parameter int WAKE_CYCLES = WAKE_TICK_CYCLES
) (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst,
    // Register port
    input  wire reg_req_t     bus_req,
    output logic [31:0]       rd_data,
    // Host interface and receiver
    input  wire logic         host_chip_select_n,
    input  wire logic         external_field_detect,
    input  wire gain_sample_t live_gain,
    input  wire logic         field_on_done,
    // Transmitter and regulator
    output logic              rf_field_on,
    output logic              typea_tx_settings,
    output logic              field_on_command,
    output logic              regulator_control_output,
    // Status
    output logic              detect_interrupt,
    output logic              sensing_busy
);

    // ========================================================================
    // Helpers
    // ========================================================================
    function automatic logic [15:0] scale(input logic [7:0] count,
                                          input logic [3:0] step_us);
        scale = 16'(count) * 16'(step_us);
    endfunction

    function automatic logic addr_is(input logic [7:0] a,
                                     input logic [7:0] b);
        addr_is = (a == b);
    endfunction

    // ========================================================================
    // Declarations
    // ========================================================================
    logic [15:0]          ref_store;
    logic [7:0]           field_on_time;
    logic [7:0]           wake_threshold;
    logic [7:0]           ref_select;
    logic [7:0]           lead_time;
    logic [7:0]           lag_time;
    logic                 dpc_active;
    logic [15:0]          standby_len;
    logic [31:0]          detect_result;
    logic                 detect_flag;

    sense_state_t         state;
    sense_state_t         next_state;
    logic [15:0]          timer;
    logic [15:0]          next_timer;
    logic                 single_shot;
    logic                 measure_pending;
    logic                 cycle_reg_en;
    logic                 hit_q;
    gain_sample_t         reference;

    logic                 us_tick;
    logic                 wake_tick;
    logic                 tick;
    logic                 timer_done;
    logic                 entering;
    logic                 start_loop;
    logic                 start_check;
    logic                 leave_req;
    logic                 hit_raw;
    logic                 hit_now;
    logic                 sample_end;
    logic                 status_clear;
    logic                 run_reg_en;
    logic                 hit_exit;

    // ========================================================================
    // Time bases
    // ========================================================================
    tick_divider #(
        .DIV     (US_CYCLES)
    ) u_us_tick (
        .ref_clk (ref_clk),
        .rst     (rst),
        .restart (entering),
        .tick    (us_tick)
    );

    // Stands in for the slow wake oscillator; its tick times the standby.
    tick_divider #(
        .DIV     (WAKE_CYCLES)
    ) u_wake_tick (
        .ref_clk (ref_clk),
        .rst     (rst),
        .restart (entering),
        .tick    (wake_tick)
    );

    gain_compare u_compare (
        .reference (reference),
        .current   (live_gain),
        .threshold (wake_threshold),
        .hit       (hit_raw)
    );

    // ========================================================================
    // Sequencer decode
    // ========================================================================
    assign tick        = (state == ST_STANDBY) ? wake_tick : us_tick;
    assign timer_done  = (timer == 16'h0000) ||
                         (tick && timer == 16'h0001);
    assign entering    = (next_state != state);
    assign start_loop  = bus_req.wr && state == ST_IDLE &&
                         addr_is(bus_req.addr, ADDR_SENSE_COMMAND);
    assign start_check = bus_req.wr && state == ST_IDLE &&
                         addr_is(bus_req.addr, ADDR_DETECT_RESULT);
    assign leave_req   = !host_chip_select_n || external_field_detect;
    assign sample_end  = state == ST_FIELD_ON && timer_done;
    assign run_reg_en  = (start_loop || start_check) ?
                         ref_select[SEL_REG_EN_BIT] : cycle_reg_en;
    assign hit_exit    = next_state == ST_IDLE &&
                         ((sample_end && hit_now) ||
                          (state == ST_LAG && hit_q));
    // A measuring pass only fetches the reference and never wakes.
    assign hit_now     = hit_raw && !measure_pending;
    assign status_clear = bus_req.wr &&
                          addr_is(bus_req.addr, ADDR_SENSE_STATUS) &&
                          bus_req.wdata[STAT_DETECT_BIT];

    // Where the detection phase starts depends on regulator and power control.
    function automatic sense_state_t detect_entry(input logic reg_en,
                                                  input logic dynamic_power_control);
        if (reg_en) begin
            detect_entry = ST_LEAD;
        end else if (dynamic_power_control) begin
            detect_entry = ST_FIELD_START;
        end else begin
            detect_entry = ST_FIELD_ON;
        end
    endfunction

    // After a detection phase: stop on a card or a one-shot, else sleep again.
    function automatic sense_state_t after_detect(input logic hit,
                                                  input logic once);
        if (hit || once) begin
            after_detect = ST_IDLE;
        end else begin
            after_detect = ST_STANDBY;
        end
    endfunction

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (start_loop) begin
                    next_state = ST_STANDBY;
                end else if (start_check) begin
                    next_state = detect_entry(run_reg_en, dpc_active);
                end
            end
            ST_STANDBY: begin
                if (timer_done) begin
                    next_state = detect_entry(run_reg_en, dpc_active);
                end
            end
            ST_LEAD: begin
                if (timer_done) begin
                    next_state = dpc_active ? ST_FIELD_START : ST_FIELD_ON;
                end
            end
            ST_FIELD_START: begin
                if (field_on_done) begin
                    next_state = ST_FIELD_ON;
                end
            end
            ST_FIELD_ON: begin
                if (timer_done) begin
                    next_state = cycle_reg_en ? ST_LAG :
                                 after_detect(hit_now, single_shot);
                end
            end
            ST_LAG: begin
                if (timer_done) begin
                    next_state = after_detect(hit_q, single_shot);
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        if (state != ST_IDLE && leave_req) begin
            next_state = ST_IDLE;
        end
    end

    // Each timed phase loads its own length on entry; field start loads none.
    always_comb begin
        next_timer = 16'h0000;
        case (next_state)
            ST_STANDBY:  next_timer = standby_len;
            ST_LEAD:     next_timer = scale(lead_time, REG_STEP_US);
            ST_FIELD_ON: next_timer = scale(field_on_time,
                                            FIELD_STEP_US);
            ST_LAG:      next_timer = scale(lag_time, REG_STEP_US);
            default:     next_timer = 16'h0000;
        endcase
    end

    // ========================================================================
    // Sequencer state and timer
    // ========================================================================
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
            timer <= 16'h0000;
        end else begin
            state <= next_state;
            if (entering) begin
                timer <= next_timer;
            end else if (tick && !timer_done) begin
                timer <= timer - 16'h0001;
            end
        end
    end

    // ========================================================================
    // Per-run context: reference, mode and verdict
    // ========================================================================
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            single_shot     <= 1'b0;
            measure_pending <= 1'b0;
            cycle_reg_en    <= 1'b0;
            hit_q           <= 1'b0;
            reference       <= '0;
        end else begin
            if (start_loop || start_check) begin
                single_shot     <= start_check;
                measure_pending <= ref_select[SEL_SRC_MSB:0] == SRC_MEASURE;
                cycle_reg_en    <= ref_select[SEL_REG_EN_BIT];
                hit_q           <= 1'b0;
                case (ref_select[SEL_SRC_MSB:0])
                    SRC_LIVE: reference <= live_gain;
                    default: begin
                        reference.value <= ref_store[REF_VALUE_MSB:0];
                        reference.gear  <=
                            ref_store[REF_GEAR_MSB:REF_GEAR_LSB];
                    end
                endcase
            end else if (sample_end) begin
                hit_q <= hit_now;
                if (measure_pending) begin
                    reference       <= live_gain;
                    measure_pending <= 1'b0;
                end
            end
        end
    end

    // ========================================================================
    // Detection flag and one-shot result
    // ========================================================================
    // The flag is set in loop mode only, as the run ends, so the interrupt
    // rises the cycle after busy falls; a new detection wins over a clear.
    // Host configuration is left untouched here, so the host must reload its
    // protocol settings itself before polling.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            detect_flag <= 1'b0;
        end else if (hit_exit && !single_shot) begin
            detect_flag <= 1'b1;
        end else if (status_clear) begin
            detect_flag <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            detect_result <= 32'h0000_0000;
        end else if (sample_end && single_shot) begin
            detect_result <= 32'h0000_0000;
            detect_result[RES_HIT_BIT] <= hit_now;
            detect_result[RES_GAIN_LSB +: 10] <= live_gain.value;
        end
    end

    // ========================================================================
    // Configuration registers
    // ========================================================================
    // The host must have a valid reference here, or select a measured or
    // live source, before starting the loop.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ref_store      <= RST_REF_STORE;
            field_on_time  <= RST_BYTE;
            wake_threshold <= RST_BYTE;
            ref_select     <= RST_BYTE;
            lead_time      <= RST_BYTE;
            lag_time       <= RST_BYTE;
            dpc_active     <= 1'b0;
            standby_len    <= 16'h0000;
        end else if (bus_req.wr) begin
            case (bus_req.addr)
                ADDR_REF_STORE:      ref_store      <= bus_req.wdata[15:0];
                ADDR_FIELD_ON_TIME:  field_on_time  <= bus_req.wdata[7:0];
                ADDR_WAKE_THRESHOLD: wake_threshold <= bus_req.wdata[7:0];
                ADDR_REF_SELECT:     ref_select     <= bus_req.wdata[7:0];
                ADDR_REG_LEAD:       lead_time      <= bus_req.wdata[7:0];
                ADDR_REG_LAG:        lag_time       <= bus_req.wdata[7:0];
                ADDR_SENSE_CONTROL:  dpc_active     <=
                                         bus_req.wdata[CTRL_DPC_BIT];
                ADDR_SENSE_COMMAND: begin
                    if (state == ST_IDLE) begin
                        standby_len <= bus_req.wdata[STANDBY_W-1:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ========================================================================
    // Read port
    // ========================================================================
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rd_data <= 32'h0000_0000;
        end else if (bus_req.rd) begin
            rd_data <= 32'h0000_0000;
            case (bus_req.addr)
                ADDR_DETECT_RESULT:  rd_data <= detect_result;
                ADDR_REF_STORE:      rd_data[15:0] <= ref_store;
                ADDR_FIELD_ON_TIME:  rd_data[7:0] <= field_on_time;
                ADDR_WAKE_THRESHOLD: rd_data[7:0] <= wake_threshold;
                ADDR_REF_SELECT:     rd_data[7:0] <= ref_select;
                ADDR_REG_LEAD:       rd_data[7:0] <= lead_time;
                ADDR_REG_LAG:        rd_data[7:0] <= lag_time;
                ADDR_SENSE_CONTROL:  rd_data[CTRL_DPC_BIT] <= dpc_active;
                ADDR_SENSE_COMMAND:  rd_data[15:0] <= standby_len;
                ADDR_SENSE_STATUS: begin
                    rd_data[STAT_DETECT_BIT] <= detect_flag;
                    rd_data[STAT_BUSY_BIT]   <= state != ST_IDLE;
                    rd_data[STAT_STATE_LSB +: 6] <= state;
                end
                default: begin
                end
            endcase
        end else begin
            rd_data <= 32'h0000_0000;
        end
    end

    // ========================================================================
    // Pin outputs
    // ========================================================================
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rf_field_on              <= 1'b0;
            typea_tx_settings        <= 1'b0;
            field_on_command         <= 1'b0;
            regulator_control_output <= 1'b0;
            detect_interrupt         <= 1'b0;
            sensing_busy             <= 1'b0;
        end else begin
            rf_field_on <= next_state == ST_FIELD_START ||
                           next_state == ST_FIELD_ON;
            typea_tx_settings <= next_state == ST_FIELD_ON &&
                                 !dpc_active;
            field_on_command <= next_state == ST_FIELD_START &&
                                entering;
            regulator_control_output <= run_reg_en &&
                (next_state == ST_LEAD || next_state == ST_FIELD_START ||
                 next_state == ST_FIELD_ON ||
                 next_state == ST_LAG);
            detect_interrupt <= detect_flag;
            sensing_busy     <= next_state != ST_IDLE;
        end
    end

endmodule

// [common/sense_pkg.sv]
// Constants, register map and types for the card-presence sensing block.
package sense_pkg;

    // ========================================================================
    // Register port widths and register indices
    // ========================================================================
    localparam int          ADDR_W              = 8;
    localparam int          DATA_W              = 32;
    localparam logic [7:0]  ADDR_DETECT_RESULT  = 8'h26;
    localparam logic [7:0]  ADDR_REF_STORE      = 8'h34;
    localparam logic [7:0]  ADDR_FIELD_ON_TIME  = 8'h36;
    localparam logic [7:0]  ADDR_WAKE_THRESHOLD = 8'h37;
    localparam logic [7:0]  ADDR_REF_SELECT     = 8'h38;
    localparam logic [7:0]  ADDR_REG_LEAD       = 8'h39;
    localparam logic [7:0]  ADDR_REG_LAG        = 8'h3A;
    localparam logic [7:0]  ADDR_SENSE_COMMAND  = 8'h40;
    localparam logic [7:0]  ADDR_SENSE_STATUS   = 8'h41;
    localparam logic [7:0]  ADDR_SENSE_CONTROL  = 8'h42;

    // ========================================================================
    // Field positions
    // ========================================================================
    localparam int          REF_VALUE_MSB       = 9;
    localparam int          REF_GEAR_LSB        = 10;
    localparam int          REF_GEAR_MSB        = 13;
    localparam int          SEL_SRC_MSB         = 1;
    localparam int          SEL_REG_EN_BIT      = 2;
    localparam int          CTRL_DPC_BIT        = 0;
    localparam int          STAT_DETECT_BIT     = 0;
    localparam int          STAT_BUSY_BIT       = 1;
    localparam int          STAT_STATE_LSB      = 8;
    localparam int          RES_HIT_BIT         = 0;
    localparam int          RES_GAIN_LSB        = 16;
    localparam int          STANDBY_W           = 16;

    // ========================================================================
    // Reference sources and reset values
    // ========================================================================
    localparam logic [1:0]  SRC_STORED          = 2'h0;
    localparam logic [1:0]  SRC_MEASURE         = 2'h1;
    localparam logic [1:0]  SRC_LIVE            = 2'h2;
    localparam logic [15:0] RST_REF_STORE       = 16'h0000;
    localparam logic [7:0]  RST_BYTE            = 8'h00;

    // ========================================================================
    // Timing
    // ========================================================================
    localparam int          CLK_HZ              = 50_000_000;
    localparam int          US_CYCLES           = CLK_HZ / 1_000_000;
    localparam logic [3:0]  FIELD_STEP_US       = 4'h8;
    localparam logic [3:0]  REG_STEP_US         = 4'h5;
    localparam int          WAKE_TICK_US        = 1000;
    localparam int          WAKE_TICK_CYCLES    = WAKE_TICK_US * US_CYCLES;

    // ========================================================================
    // Types
    // ========================================================================
    typedef enum logic [5:0] {
        ST_IDLE        = 6'h01,
        ST_STANDBY     = 6'h02,
        ST_LEAD        = 6'h04,
        ST_FIELD_START = 6'h08,
        ST_FIELD_ON    = 6'h10,
        ST_LAG         = 6'h20
    } sense_state_t;

    typedef struct packed {
        logic [3:0] gear;
        logic [9:0] value;
    } gain_sample_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } reg_req_t;

endpackage

// [src/tick_divider.sv]
// One-cycle enable pulse every DIV clock cycles, restartable.
`timescale 1ns/1ps
module tick_divider #(
    parameter int DIV = 50
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // Control and tick
    input  wire logic restart,
    output logic      tick
);
    logic [31:0] count;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            count <= 32'h0000_0000;
            tick  <= 1'b0;
        end else if (restart || count == 32'(DIV - 1)) begin
            count <= 32'h0000_0000;
            tick  <= !restart;
        end else begin
            count <= count + 32'h0000_0001;
            tick  <= 1'b0;
        end
    end
endmodule

// [src/gain_compare.sv]
// Decides whether a gain sample departs from the reference by more than a threshold.
`timescale 1ns/1ps
module gain_compare
    import sense_pkg::*;
(
    // Operands
    input  wire gain_sample_t reference,
    input  wire gain_sample_t current,
    input  wire logic [7:0]   threshold,
    // Result
    output logic              hit
);
    function automatic logic [9:0] abs_diff(input logic [9:0] a,
                                            input logic [9:0] b);
        abs_diff = (a >= b) ? a - b : b - a;
    endfunction

    // A drift in either direction counts, since metal can pull gain both ways.
    assign hit = abs_diff(reference.value, current.value) > {2'h0, threshold};
endmodule

// [tb/sense_monitor.sv]
// Port checker for the card-presence sensing sequencer.
`timescale 1ns/1ps
module sense_monitor
    import sense_pkg::*;
(
    // Clock and reset
    input wire logic     ref_clk, rst,
    // Observed ports
    input wire reg_req_t bus_req,
    input wire logic     host_chip_select_n, external_field_detect,
    input wire logic     rf_field_on, typea_tx_settings, field_on_command,
    input wire logic     regulator_control_output, detect_interrupt,
    input wire logic     sensing_busy
);
    // ==========
    // Properties
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire clr = bus_req.wr && bus_req.addr == ADDR_SENSE_STATUS
        && bus_req.wdata[0];
    wire go = bus_req.wr && (bus_req.addr == ADDR_SENSE_COMMAND
        || bus_req.addr == ADDR_DETECT_RESULT);
    sequence s_abort;
        sensing_busy && (!host_chip_select_n || external_field_detect);
    endsequence
    a_typea_field:
        assert property (typea_tx_settings |-> rf_field_on) else $error("t");
    a_cmd_pulse:
        assert property (field_on_command |=> !field_on_command) else $error("c");
    a_irq_idle:
        assert property ($rose(detect_interrupt) |-> !sensing_busy) else $error("i");
    a_abort_exit:
        assert property (s_abort |-> ##[1:2] !sensing_busy) else $error("a");
    a_lead_first:
        assert property ($rose(regulator_control_output) |-> !rf_field_on)
        else $error("l");
    a_lag_hold:
        assert property ($fell(rf_field_on) && regulator_control_output
            |=> regulator_control_output) else $error("g");
    a_irq_sticky:
        assert property (detect_interrupt && !$past(clr) |=> detect_interrupt)
        else $error("s");
    a_busy_start:
        assert property ($rose(sensing_busy) |-> $past(go) || $past(go, 2))
        else $error("b");
endmodule
bind card_presence_sensing sense_monitor mon (.ref_clk(ref_clk), .rst(rst),
    .bus_req(bus_req), .host_chip_select_n(host_chip_select_n),
    .external_field_detect(external_field_detect), .rf_field_on(rf_field_on),
    .typea_tx_settings(typea_tx_settings),
    .field_on_command(field_on_command),
    .regulator_control_output(regulator_control_output),
    .detect_interrupt(detect_interrupt), .sensing_busy(sensing_busy));

// [tb/gain_source.sv]
// Receiver model giving gain samples and field-on completion.
`timescale 1ns/1ps
module gain_source
    import sense_pkg::*;
(
    // Clock, field and level to report
    input  wire logic         ref_clk, rf_field_on, field_on_command,
    input  wire gain_sample_t level,
    // Receiver answers
    output gain_sample_t      live_gain,
    output logic              field_on_done
);
    // ==========
    // Behaviour
    logic [3:0] wait_cnt = 4'h0;
    // With the field off nothing settles, so the sample shows the inverse.
    always_ff @(posedge ref_clk) begin
        live_gain <= rf_field_on ? level : ~level;
        if (field_on_command) wait_cnt <= 4'h6;
        else if (wait_cnt != 4'h0) wait_cnt <= wait_cnt - 4'h1;
        field_on_done <= wait_cnt == 4'h1;
    end
endmodule

// [tb/testbench.sv]
// Self-checking bench for the card-presence sensing sequencer.
`timescale 1ns/1ps
module testbench
    import sense_pkg::*;
;
    // ==========
    // Design, receiver model and one-shot table
    typedef struct packed {
        logic [7:0] thr;
        logic [9:0] ref_v, live_v;
        logic [1:0] sel;
        logic       hit;
    } row_t;
    // The live source row captures the inverted level seen with field off.
    localparam row_t ROWS [6] = '{'{8'h10, 10'h100, 10'h111, 2'h0, 1'b1},
        '{8'h10, 10'h100, 10'h110, 2'h3, 1'b0},
        '{8'h10, 10'h100, 10'h0EF, 2'h0, 1'b1},
        '{8'h00, 10'h155, 10'h155, 2'h0, 1'b0},
        '{8'h10, 10'h100, 10'h300, 2'h1, 1'b0},
        '{8'h10, 10'h100, 10'h100, 2'h2, 1'b1}};
    logic ref_clk = 1'b0, rst = 1'b1, cs_n = 1'b1, efd = 1'b0;
    logic done, fon, tya, fcmd, reg_out, irq, busy;
    reg_req_t bus_req = '0;
    gain_sample_t level = '0, live_gain;
    logic [31:0] rd_data, v;
    int bad_count = 0, check_count = 0, on_cnt = 0, ty_cnt = 0, rg_cnt = 0, n;
    card_presence_sensing #(.WAKE_CYCLES(20)) dut (.ref_clk(ref_clk),
        .rst(rst), .bus_req(bus_req), .rd_data(rd_data),
        .host_chip_select_n(cs_n), .external_field_detect(efd),
        .live_gain(live_gain), .field_on_done(done), .rf_field_on(fon),
        .typea_tx_settings(tya), .field_on_command(fcmd),
        .regulator_control_output(reg_out), .detect_interrupt(irq),
        .sensing_busy(busy));
    gain_source rx (.ref_clk(ref_clk), .rf_field_on(fon),
        .field_on_command(fcmd), .level(level), .live_gain(live_gain),
        .field_on_done(done));
    always #10 ref_clk = ~ref_clk;
    always @(negedge ref_clk) begin
        on_cnt += fon;
        ty_cnt += tya;
        rg_cnt += reg_out & ~fon;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk) bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge ref_clk) bus_req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk) bus_req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge ref_clk) bus_req.rd <= 1'b0;
        @(negedge ref_clk) v = rd_data;
    endtask
    task automatic hold(ref logic s, input logic val);
        @(negedge ref_clk);
        for (n = 0; n < 4000 && s !== val; n++) @(negedge ref_clk);
        chk("wait", {31'h0, val}, {31'h0, s});
    endtask
    task automatic chk(input string s, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        #1_000_000;
        bad_count++;
        print_verdict();
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        rd(ADDR_REF_STORE);
        chk("ref_store", 32'h0, v);
        wr(8'h50, 32'h0000_00FF);
        rd(8'h50);
        chk("unmapped", 32'h0, v);
        wr(ADDR_FIELD_ON_TIME, 32'h1);
        for (int i = 0; i < 6; i++) begin
            wr(ADDR_REF_STORE, {18'h0, 4'h3, ROWS[i].ref_v});
            wr(ADDR_WAKE_THRESHOLD, {24'h0, ROWS[i].thr});
            wr(ADDR_REF_SELECT, {30'h0, ROWS[i].sel});
            level <= '{4'h0, ROWS[i].live_v};
            on_cnt = 0;
            ty_cnt = 0;
            wr(ADDR_DETECT_RESULT, 32'h1);
            hold(busy, 1'b0);
            rd(ADDR_DETECT_RESULT);
            chk("hit", {31'h0, ROWS[i].hit}, {31'h0, v[0]});
            chk("gain", {22'h0, ROWS[i].live_v}, {22'h0, v[25:16]});
            chk("on_time", 32'h1, {31'h0, on_cnt inside {[399:401]}});
            chk("typea", 32'h1, {31'h0, ty_cnt inside {[399:401]}});
            chk("no_irq", 32'h0, {31'h0, irq});
        end
        wr(ADDR_REF_SELECT, 32'h0);
        on_cnt = 0;
        wr(ADDR_SENSE_COMMAND, 32'h1);
        repeat (1500) @(posedge ref_clk);
        chk("repeat", 32'h1, {31'h0, busy && on_cnt > 800});
        chk("loop_irq", 32'h0, {31'h0, irq});
        cs_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk("cs_exit", 32'h0, {31'h0, busy});
        cs_n <= 1'b1;
        wr(ADDR_REF_SELECT, 32'h4);
        wr(ADDR_REG_LEAD, 32'h1);
        wr(ADDR_REG_LAG, 32'h1);
        wr(ADDR_SENSE_CONTROL, 32'h1);
        level <= '{4'h0, 10'h120};
        ty_cnt = 0;
        rg_cnt = 0;
        wr(ADDR_SENSE_COMMAND, 32'h2);
        hold(irq, 1'b1);
        chk("detect", 32'h1, {31'h0, irq & ~busy});
        chk("dpc_typea", 32'h0, ty_cnt);
        chk("reg_wait", 32'h1, {31'h0, rg_cnt inside {[497:503]}});
        wr(ADDR_SENSE_STATUS, 32'h1);
        repeat (2) @(posedge ref_clk);
        chk("irq_clear", 32'h0, {31'h0, irq});
        wr(ADDR_SENSE_COMMAND, 32'h1);
        efd <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk("field_exit", 32'h0, {31'h0, busy});
        print_verdict();
    end
endmodule
